// *** pkg/fam_pkg.sv ***
package fam_pkg;

    // ==========================================
    // Alert sources
    // ==========================================
    localparam int NUM_SRC = 12;
    localparam int SRC_W = 4;
    localparam int TEXT_CHARS = 32;
    localparam int TEXT_W = TEXT_CHARS * 8;
    localparam int ENG_W = 2;

    // Source indices: red class first, then amber class
    localparam logic [SRC_W-1:0] SRC_GND_PROX = 4'h0;
    localparam logic [SRC_W-1:0] SRC_NEVER_EXCEED = 4'h1;
    localparam logic [SRC_W-1:0] SRC_AP_DISENGAGE = 4'h2;
    localparam logic [SRC_W-1:0] SRC_MAN_PRES = 4'h3;
    localparam logic [SRC_W-1:0] SRC_RPM = 4'h4;
    localparam logic [SRC_W-1:0] SRC_DOOR = 4'h5;
    localparam logic [SRC_W-1:0] SRC_GEAR = 4'h6;
    localparam logic [SRC_W-1:0] SRC_WING_FLAPS = 4'h7;
    localparam logic [SRC_W-1:0] SRC_COWL_FLAPS = 4'h8;
    localparam logic [SRC_W-1:0] SRC_TRIM = 4'h9;
    localparam logic [SRC_W-1:0] SRC_AUX_PUMPS = 4'hA;
    localparam logic [SRC_W-1:0] SRC_STALL_MARGIN = 4'hB;

    // Sources 0..2 are red warnings, the rest amber cautions
    localparam logic [NUM_SRC-1:0] WARN_CLASS_MASK = 12'h007;

    // Engine qualifier codes
    localparam logic [ENG_W-1:0] ENG_NONE = 2'h0;
    localparam logic [ENG_W-1:0] ENG_LEFT = 2'h1;
    localparam logic [ENG_W-1:0] ENG_RIGHT = 2'h2;
    localparam logic [ENG_W-1:0] ENG_BOTH = 2'h3;

    // Blank display slot code
    localparam logic [SRC_W-1:0] SRC_IDLE = 4'hF;

    // Light flash half period
    localparam int CLK_HZ = 20000000;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;

    // Message classes
    typedef enum logic [1:0] {
        CLS_NONE = 2'b00,
        CLS_UNACK_WARN = 2'b01,
        CLS_UNACK_CAUT = 2'b11,
        CLS_ACKED = 2'b10
    } fam_class_t;

endpackage

// *** rtl/fam_btn_sync.sv ***
`timescale 1ns/1ps
module fam_btn_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic btn,
    output logic press
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    wire rise = s2_q & ~s3_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            press <= 1'b0;
        end else begin
            s1_q <= btn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            press <= rise;
        end
    end
endmodule

// *** rtl/fam_text_rom.sv ***
`timescale 1ns/1ps
module fam_text_rom (
    input wire logic clk,
    input wire logic [fam_pkg::SRC_W-1:0] src,
    input wire logic [fam_pkg::ENG_W-1:0] eng,
    output logic [fam_pkg::TEXT_W-1:0] text
);
    localparam int TW = fam_pkg::TEXT_W;
    logic [TW-1:0] base;
    logic [TW-1:0] qual;
    logic [TW-1:0] line;

    // Message text per source, left justified and space padded
    always_comb begin
        case (src)
            fam_pkg::SRC_GND_PROX: base = {"GROUND PROXIMITY", {16{" "}}};
            fam_pkg::SRC_NEVER_EXCEED: base = {"NEVER EXCEED AIRSPEED", {11{" "}}};
            fam_pkg::SRC_AP_DISENGAGE: base = {"AUTOPILOT DISENGAGE", {13{" "}}};
            fam_pkg::SRC_MAN_PRES: base = {"HI MAN PRES", {21{" "}}};
            fam_pkg::SRC_RPM: base = {"HI RPM", {26{" "}}};
            fam_pkg::SRC_DOOR: base = {"DOOR NOT LATCHED", {16{" "}}};
            fam_pkg::SRC_GEAR: base = {"LDG GEAR", {24{" "}}};
            fam_pkg::SRC_WING_FLAPS: base = {"WING FLAPS", {22{" "}}};
            fam_pkg::SRC_COWL_FLAPS: base = {"COWL FLAPS CLOSED", {15{" "}}};
            fam_pkg::SRC_TRIM: base = {"OUT OF TRIM", {21{" "}}};
            fam_pkg::SRC_AUX_PUMPS: base = {"AUX FUEL PUMPS OFF", {14{" "}}};
            fam_pkg::SRC_STALL_MARGIN: base = {"1.2 VSTALL", {22{" "}}};
            default: base = {32{" "}};
        endcase
    end

    // Engine suffix in the last three characters
    always_comb begin
        case (eng)
            fam_pkg::ENG_LEFT: qual = {{29{" "}}, " LE"};
            fam_pkg::ENG_RIGHT: qual = {{29{" "}}, " RE"};
            fam_pkg::ENG_BOTH: qual = {{29{" "}}, " BE"};
            default: qual = {32{" "}};
        endcase
    end

    assign line = (eng == fam_pkg::ENG_NONE) ? base : {base[TW-1:24], qual[23:0]};

    always_ff @(posedge clk) begin
        text <= line;
    end
endmodule

// *** rtl/fam_alert_manager.sv ***
`timescale 1ns/1ps
module fam_alert_manager #(
    parameter int NUM_SRC = fam_pkg::NUM_SRC,
    parameter int FLASH_HALF_CYC = fam_pkg::FLASH_HALF_CYC
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [NUM_SRC-1:0] COND_ACTIVE,
    input wire logic [2*NUM_SRC-1:0] COND_ENGINE,
    input wire logic MESSAGE_ACKNOWLEDGE_BUTTON,
    output logic RED_LIGHT,
    output logic AMBER_LIGHT,
    output logic [fam_pkg::TEXT_W-1:0] CONTROL_DISPLAY_UNIT_TEXT,
    output logic [fam_pkg::SRC_W-1:0] SHOWN_SOURCE,
    output logic [1:0] SHOWN_CLASS
);
    localparam int SW = fam_pkg::SRC_W;
    // Wide stamps so arrival order survives long runs before the counter saturates
    localparam int AW = 16;
    localparam int FW = $clog2(FLASH_HALF_CYC + 1);

    // ==========================================
    // Input synchronisers
    // ==========================================
    logic [NUM_SRC-1:0] act_s1_q;
    logic [NUM_SRC-1:0] act_q;
    logic [2*NUM_SRC-1:0] eng_s1_q;
    logic [2*NUM_SRC-1:0] eng_q;
    logic ack_press;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            act_s1_q <= '0;
            act_q <= '0;
            eng_s1_q <= '0;
            eng_q <= '0;
        end else begin
            act_s1_q <= COND_ACTIVE;
            act_q <= act_s1_q;
            eng_s1_q <= COND_ENGINE;
            eng_q <= eng_s1_q;
        end
    end

    fam_btn_sync u_btn (
        .clk(CLK),
        .reset(RESET),
        .btn(MESSAGE_ACKNOWLEDGE_BUTTON),
        .press(ack_press)
    );

    // ==========================================
    // Per-source class and arrival order
    // ==========================================
    // Each source holds one class code and an age stamp; smaller stamp is older.
    fam_pkg::fam_class_t cls_q [NUM_SRC];
    logic [AW-1:0] age_q [NUM_SRC];
    logic [AW-1:0] cnt_q;
    logic [NUM_SRC-1:0] is_warn;
    logic [NUM_SRC-1:0] is_caut;
    logic [NUM_SRC-1:0] is_ack;
    logic [NUM_SRC-1:0] rise;
    logic [NUM_SRC-1:0] fall;
    logic [NUM_SRC-1:0] stamped;

    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_cls
            assign is_warn[g] = (cls_q[g] == fam_pkg::CLS_UNACK_WARN);
            assign is_caut[g] = (cls_q[g] == fam_pkg::CLS_UNACK_CAUT);
            assign is_ack[g] = (cls_q[g] == fam_pkg::CLS_ACKED);
            assign stamped[g] = (cls_q[g] != fam_pkg::CLS_NONE);
            assign rise[g] = act_q[g] & ~stamped[g];
            assign fall[g] = ~act_q[g] & stamped[g];
        end
    endgenerate

    // ==========================================
    // Oldest selection per class
    // ==========================================
    logic [SW-1:0] old_warn;
    logic [SW-1:0] old_caut;
    logic [SW-1:0] top_ack;
    logic [SW-1:0] next_ack;
    logic any_warn;
    logic any_caut;
    logic any_ack;
    logic [SW-1:0] shown_q;
    logic [AW-1:0] shown_age;

    assign shown_age = (shown_q < SW'(NUM_SRC)) ? age_q[shown_q] : '0;

    always_comb begin
        logic [AW-1:0] bw;
        logic [AW-1:0] bc;
        logic [AW-1:0] ba;
        logic [AW-1:0] bn;
        bw = '1;
        bc = '1;
        ba = '1;
        bn = '1;
        old_warn = fam_pkg::SRC_IDLE;
        old_caut = fam_pkg::SRC_IDLE;
        top_ack = fam_pkg::SRC_IDLE;
        next_ack = fam_pkg::SRC_IDLE;
        any_warn = 1'b0;
        any_caut = 1'b0;
        any_ack = 1'b0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (is_warn[i] && act_q[i] && (!any_warn || age_q[i] < bw)) begin
                bw = age_q[i];
                old_warn = SW'(i);
                any_warn = 1'b1;
            end
            if (is_caut[i] && act_q[i] && (!any_caut || age_q[i] < bc)) begin
                bc = age_q[i];
                old_caut = SW'(i);
                any_caut = 1'b1;
            end
            // Stack order only, no class priority
            if (is_ack[i] && act_q[i] && (!any_ack || age_q[i] < ba)) begin
                ba = age_q[i];
                top_ack = SW'(i);
                any_ack = 1'b1;
            end
            // Next entry below the shown one
            if (is_ack[i] && act_q[i] && age_q[i] > shown_age && (next_ack == fam_pkg::SRC_IDLE || age_q[i] < bn)) begin
                bn = age_q[i];
                next_ack = SW'(i);
            end
        end
    end

    // ==========================================
    // Display selection
    // ==========================================
    logic stack_mode_q;
    wire shown_is_ack = (shown_q < SW'(NUM_SRC)) && is_ack[shown_q] && act_q[shown_q];
    wire step_ack = ack_press && !any_warn && !any_caut && shown_is_ack && stack_mode_q;
    wire [SW-1:0] step_target = (next_ack != fam_pkg::SRC_IDLE) ? next_ack : top_ack;
    wire [SW-1:0] ack_target = any_warn ? old_warn : old_caut;
    wire do_ack = ack_press && (any_warn || any_caut);
    logic [SW-1:0] sel_d;

    always_comb begin
        if (any_warn) begin
            sel_d = old_warn;
        end else if (any_caut) begin
            sel_d = old_caut;
        end else if (step_ack) begin
            sel_d = step_target;
        end else if (shown_is_ack && stack_mode_q) begin
            sel_d = shown_q;
        end else begin
            sel_d = top_ack;
        end
    end

    // ==========================================
    // Class update
    // ==========================================
    // Messages follow their conditions
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_upd
            wire acked_now = do_ack && (ack_target == SW'(g));
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    cls_q[g] <= fam_pkg::CLS_NONE;
                    age_q[g] <= '0;
                end else if (fall[g]) begin
                    cls_q[g] <= fam_pkg::CLS_NONE;
                end else if (rise[g]) begin
                    cls_q[g] <= fam_pkg::WARN_CLASS_MASK[g] ? fam_pkg::CLS_UNACK_WARN : fam_pkg::CLS_UNACK_CAUT;
                    age_q[g] <= cnt_q;
                end else if (acked_now) begin
                    cls_q[g] <= fam_pkg::CLS_ACKED;
                    age_q[g] <= cnt_q;
                end
            end
        end
    endgenerate

    // Stamp counter, restarts when nothing is held
    wire stamp_use = (|rise) || do_ack;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            cnt_q <= '0;
        end else if (~|stamped && ~|rise) begin
            cnt_q <= '0;
        end else if (stamp_use && cnt_q != '1) begin
            cnt_q <= cnt_q + AW'(1);
        end
    end

    // ==========================================
    // Lights
    // ==========================================
    logic [FW-1:0] flash_cnt_q;
    logic flash_q;

    always_ff @(posedge CLK) begin
        if (RESET) begin
            flash_cnt_q <= '0;
            flash_q <= 1'b0;
        end else if (flash_cnt_q == FW'(FLASH_HALF_CYC - 1)) begin
            flash_cnt_q <= '0;
            flash_q <= ~flash_q;
        end else begin
            flash_cnt_q <= flash_cnt_q + FW'(1);
        end
    end

    wire red_d = any_warn && !(do_ack && ack_target == old_warn && !(|(is_warn & act_q & ~(WARN_SEL(old_warn)))))
        && flash_q;
    wire amber_d = any_caut && flash_q;

    function automatic logic [NUM_SRC-1:0] WARN_SEL(input logic [SW-1:0] s);
        WARN_SEL = '0;
        if (s < SW'(NUM_SRC)) begin
            WARN_SEL[s] = 1'b1;
        end
    endfunction

    // ==========================================
    // Outputs
    // ==========================================
    logic [SW-1:0] text_src;
    logic [fam_pkg::ENG_W-1:0] text_eng;
    logic [fam_pkg::TEXT_W-1:0] text_line;

    assign text_src = shown_q;
    assign text_eng = (shown_q < SW'(NUM_SRC)) ? eng_q[2*shown_q +: 2] : fam_pkg::ENG_NONE;

    fam_text_rom u_rom (
        .clk(CLK),
        .src(text_src),
        .eng(text_eng),
        .text(text_line)
    );

    always_ff @(posedge CLK) begin
        if (RESET) begin
            shown_q <= fam_pkg::SRC_IDLE;
            stack_mode_q <= 1'b0;
            RED_LIGHT <= 1'b0;
            AMBER_LIGHT <= 1'b0;
            SHOWN_CLASS <= 2'b00;
        end else begin
            shown_q <= sel_d;
            // Entering stack view starts at top
            stack_mode_q <= !any_warn && !any_caut;
            RED_LIGHT <= red_d;
            AMBER_LIGHT <= amber_d && !any_warn ? amber_d : (any_caut && flash_q);
            SHOWN_CLASS <= (shown_q < SW'(NUM_SRC)) ? cls_q[shown_q] : fam_pkg::CLS_NONE;
        end
    end

    assign SHOWN_SOURCE = shown_q;
    assign CONTROL_DISPLAY_UNIT_TEXT = text_line;
endmodule

// *** bench/fam_pilot_model.sv ***
`timescale 1ns/1ps
module fam_pilot_model (
    input wire logic clk,
    output logic [fam_pkg::NUM_SRC-1:0] cond,
    output logic [2*fam_pkg::NUM_SRC-1:0] eng,
    output logic btn
);
    // ==========================================
    // Monitors and button
    // ==========================================
    initial begin
        cond = '0;
        eng = '0;
        btn = 1'b0;
    end
    task automatic set_cond(input int i, input logic [1:0] e, input logic v);
        @(negedge clk);
        cond[i] = v;
        eng[2*i +: 2] = v ? e : fam_pkg::ENG_NONE;
    endtask
    task automatic press(input int hold);
        @(negedge clk);
        btn = 1'b1;
        repeat (hold) @(negedge clk);
        btn = 1'b0;
        repeat (4) @(negedge clk);
    endtask
endmodule

// *** bench/fam_alert_manager_checker.sv ***
`timescale 1ns/1ps
module fam_alert_manager_checker #(
    parameter int NUM_SRC = 12,
    parameter int FLASH_HALF_CYC = 4
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [NUM_SRC-1:0] COND_ACTIVE,
    input wire logic [2*NUM_SRC-1:0] COND_ENGINE,
    input wire logic MESSAGE_ACKNOWLEDGE_BUTTON,
    input wire logic RED_LIGHT,
    input wire logic AMBER_LIGHT,
    input wire logic [fam_pkg::TEXT_W-1:0] CONTROL_DISPLAY_UNIT_TEXT,
    input wire logic [fam_pkg::SRC_W-1:0] SHOWN_SOURCE,
    input wire logic [1:0] SHOWN_CLASS
);
    // ==========================================
    // Helper history
    // ==========================================
    logic [NUM_SRC-1:0] h1_q, h2_q, h3_q, h4_q, hist;
    logic r_q;
    int st_q, wc_q;
    assign hist = COND_ACTIVE | h1_q | h2_q | h3_q | h4_q;
    always_ff @(posedge CLK) begin
        h1_q <= COND_ACTIVE;
        h2_q <= h1_q;
        h3_q <= h2_q;
        h4_q <= h3_q;
        r_q <= RED_LIGHT;
        st_q <= (RESET || RED_LIGHT != r_q) ? 0 : st_q + 1;
        wc_q <= (!RESET && SHOWN_CLASS == fam_pkg::CLS_UNACK_WARN) ? wc_q + 1 : 0;
    end
    // ==========================================
    // Assertions
    // ==========================================
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    a_red_needs_warn: assert property ((SHOWN_CLASS != fam_pkg::CLS_UNACK_WARN)[*4] |-> $past(!RED_LIGHT, 3))
        else $error("red lit with no warning shown");
    a_amber_off_acked: assert property ((SHOWN_CLASS == fam_pkg::CLS_ACKED || SHOWN_CLASS == fam_pkg::CLS_NONE)[*4]
        |-> $past(!AMBER_LIGHT, 3))
        else $error("amber lit with nothing unacknowledged");
    a_warn_src_red: assert property (SHOWN_CLASS == fam_pkg::CLS_UNACK_WARN && $stable(SHOWN_SOURCE)
        |-> fam_pkg::WARN_CLASS_MASK[SHOWN_SOURCE])
        else $error("warning class on amber source");
    a_caut_src_amber: assert property (SHOWN_CLASS == fam_pkg::CLS_UNACK_CAUT && $stable(SHOWN_SOURCE)
        |-> SHOWN_SOURCE < NUM_SRC && !fam_pkg::WARN_CLASS_MASK[SHOWN_SOURCE])
        else $error("caution class on red source");
    a_idle_no_class: assert property ((SHOWN_SOURCE == fam_pkg::SRC_IDLE)[*2] |-> SHOWN_CLASS == fam_pkg::CLS_NONE)
        else $error("class shown with no source");
    a_idle_blank_text: assert property ((SHOWN_SOURCE == fam_pkg::SRC_IDLE)[*2]
        |-> CONTROL_DISPLAY_UNIT_TEXT == {32{8'h20}})
        else $error("text not blank while idle");
    a_shown_held: assert property (SHOWN_SOURCE != fam_pkg::SRC_IDLE |-> hist[SHOWN_SOURCE])
        else $error("shown source has no condition");
    a_flash_rate: assert property (wc_q > 2 * FLASH_HALF_CYC + 4 |-> st_q <= FLASH_HALF_CYC + 1)
        else $error("red light not flashing");
    c_red_on: cover property ($rose(RED_LIGHT));
    c_caut_amber: cover property (SHOWN_CLASS == fam_pkg::CLS_UNACK_CAUT && AMBER_LIGHT);
    c_acked: cover property (SHOWN_CLASS == fam_pkg::CLS_ACKED);
endmodule
bind fam_alert_manager fam_alert_manager_checker #(.NUM_SRC(NUM_SRC), .FLASH_HALF_CYC(FLASH_HALF_CYC)) chk_inst (
    .CLK(CLK), .RESET(RESET), .COND_ACTIVE(COND_ACTIVE), .COND_ENGINE(COND_ENGINE),
    .MESSAGE_ACKNOWLEDGE_BUTTON(MESSAGE_ACKNOWLEDGE_BUTTON), .RED_LIGHT(RED_LIGHT), .AMBER_LIGHT(AMBER_LIGHT),
    .CONTROL_DISPLAY_UNIT_TEXT(CONTROL_DISPLAY_UNIT_TEXT), .SHOWN_SOURCE(SHOWN_SOURCE), .SHOWN_CLASS(SHOWN_CLASS));

// *** bench/test_flight_alert_message_manager.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_flight_alert_message_manager;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] cond;
    logic [23:0] eng;
    logic btn, red, amber;
    logic [fam_pkg::TEXT_W-1:0] text, t1;
    logic [3:0] src;
    logic [1:0] cls;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int sp = 0;
    int wq[$], cq[$], aq[$];
    always #25 clk = ~clk;
    fam_pilot_model fam_pilot_model_inst (.clk(clk), .cond(cond), .eng(eng), .btn(btn));
    fam_alert_manager #(.FLASH_HALF_CYC(4)) fam_alert_manager_inst (
        .CLK(clk), .RESET(reset), .COND_ACTIVE(cond), .COND_ENGINE(eng), .MESSAGE_ACKNOWLEDGE_BUTTON(btn),
        .RED_LIGHT(red), .AMBER_LIGHT(amber), .CONTROL_DISPLAY_UNIT_TEXT(text), .SHOWN_SOURCE(src), .SHOWN_CLASS(cls));
    // ==========================================
    // Expected display
    // ==========================================
    function automatic logic [3:0] exp_src();
        if (wq.size() != 0) return 4'(wq[0]);
        if (cq.size() != 0) return 4'(cq[0]);
        if (aq.size() != 0) return 4'(aq[sp]);
        return fam_pkg::SRC_IDLE;
    endfunction
    function automatic logic [1:0] exp_cls();
        if (wq.size() != 0) return fam_pkg::CLS_UNACK_WARN;
        if (cq.size() != 0) return fam_pkg::CLS_UNACK_CAUT;
        if (aq.size() != 0) return fam_pkg::CLS_ACKED;
        return fam_pkg::CLS_NONE;
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check();
        logic r, a;
        r = 1'b0;
        a = 1'b0;
        repeat (6) @(negedge clk);
        for (int k = 0; k < 12; k++) begin
            @(negedge clk);
            r = r | red;
            a = a | amber;
        end
        `CHK(src, exp_src())
        `CHK(cls, exp_cls())
        `CHK(r, wq.size() != 0)
        `CHK(a, cq.size() != 0)
        `CHK(text === {32{8'h20}}, src === fam_pkg::SRC_IDLE)
    endtask
    task automatic raise(input int i, input logic [1:0] e);
        fam_pilot_model_inst.set_cond(i, e, 1'b1);
        if (fam_pkg::WARN_CLASS_MASK[i]) wq.push_back(i);
        else cq.push_back(i);
        check();
    endtask
    task automatic drop(input int i);
        int s;
        s = (wq.size() + cq.size() == 0 && aq.size() != 0) ? aq[sp] : -1;
        fam_pilot_model_inst.set_cond(i, fam_pkg::ENG_NONE, 1'b0);
        wq = wq.find(x) with (x != i);
        cq = cq.find(x) with (x != i);
        aq = aq.find(x) with (x != i);
        sp = 0;
        foreach (aq[k]) if (aq[k] == s) sp = k;
        check();
    endtask
    task automatic ack(input int hold);
        fam_pilot_model_inst.press(hold);
        if (wq.size() != 0) begin
            aq.push_back(wq.pop_front());
            sp = 0;
        end else if (cq.size() != 0) begin
            aq.push_back(cq.pop_front());
            sp = 0;
        end
        else if (aq.size() != 0) sp = (sp + 1) % aq.size();
        check();
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            fails++;
            end_sim();
        end
    end
    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        void'($urandom(36));
        repeat (4) @(negedge clk);
        reset = 1'b0;
        check();
        raise(5, fam_pkg::ENG_NONE);
        ack(2);
        raise(0, fam_pkg::ENG_NONE);
        raise(6, fam_pkg::ENG_NONE);
        ack(2);
        ack(2);
        ack(2);
        ack(2);
        ack(2);
        drop(5);
        drop(0);
        drop(6);
        raise(1, fam_pkg::ENG_NONE);
        drop(1);
        raise(3, fam_pkg::ENG_LEFT);
        raise(4, fam_pkg::ENG_BOTH);
        ack(20);
        drop(3);
        drop(4);
        raise(fam_pkg::SRC_MAN_PRES, fam_pkg::ENG_LEFT);
        t1 = text;
        drop(fam_pkg::SRC_MAN_PRES);
        raise(fam_pkg::SRC_MAN_PRES, fam_pkg::ENG_RIGHT);
        `CHK(text !== t1, 1'b1)
        drop(fam_pkg::SRC_MAN_PRES);
        for (int n = 0; n < 60; n++) begin
            int i;
            i = $urandom_range(11);
            if (!cond[i]) raise(i, 2'($urandom_range(3)));
            else if ($urandom_range(1) == 1) drop(i);
            else if (wq.size() + cq.size() != 0) ack(2);
        end
        while (wq.size() + cq.size() != 0) ack(2);
        repeat (aq.size()) ack(2);
        for (int i = 0; i < 12; i++) if (cond[i]) drop(i);
        end_sim();
    end
endmodule
